// [src/fch_pkg.sv]
// Package of constants and register map for the flash command host controller
// Notes on behaviour
// - Write only with chip and write low, output high
// - Host writes reset to leave autoselect
// - Host writes reset after timeout flag rises
// - Program is two unlocks, setup, address/data
// - Host reissues program after hardware reset
// - Bypass program is A0h then address/data
// - Bypass exit is 90h then 00h
package fch_pkg;

  // Register byte offsets on the APB side
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // Command codes written into REG_CTRL[3:0]
  localparam logic [3:0] OP_READ     = 4'h1;
  localparam logic [3:0] OP_RESET    = 4'h2;
  localparam logic [3:0] OP_AUTOSEL  = 4'h3;
  localparam logic [3:0] OP_PROGRAM  = 4'h4;
  localparam logic [3:0] OP_BYP_ENTR = 4'h5;
  localparam logic [3:0] OP_BYP_PROG = 4'h6;
  localparam logic [3:0] OP_BYP_EXIT = 4'h7;
  localparam logic [3:0] OP_RAW_WR   = 4'h8;

  // Flash command data values
  localparam logic [7:0] CMD_RESET    = 8'hF0;
  localparam logic [7:0] CMD_AUTOSEL  = 8'h90;
  localparam logic [7:0] CMD_PROG     = 8'hA0;
  localparam logic [7:0] CMD_BYPASS   = 8'h20;
  localparam logic [7:0] CMD_BYP_EX1  = 8'h90;
  localparam logic [7:0] CMD_BYP_EX2  = 8'h00;

  // Unlock cycle values; plain defaults, to be matched to the part in use
  localparam logic [19:0] UNLOCK1_ADDR = 20'h00555;
  localparam logic [7:0]  UNLOCK1_DATA = 8'hAA;
  localparam logic [19:0] UNLOCK2_ADDR = 20'h002AA;
  localparam logic [7:0]  UNLOCK2_DATA = 8'h55;

  // Autoselect offsets
  localparam logic [7:0] AS_MAKER   = 8'h00;
  localparam logic [7:0] AS_DEVICE  = 8'h01;
  localparam logic [7:0] AS_PROT_W  = 8'h02;
  localparam logic [7:0] AS_PROT_B  = 8'h04;

  // Pin timing, in ns, and derived cycle counts at 100 ns
  localparam int CLK_NS        = 100;
  localparam int T_SETUP_NS    = 100;
  localparam int T_PULSE_NS    = 100;
  localparam int T_ACCESS_NS   = 200;
  localparam int SETUP_CYC     = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC     = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_CYC    = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] SETUP_CNT  = 4'(SETUP_CYC);
  localparam logic [3:0] PULSE_CNT  = 4'(PULSE_CYC);
  localparam logic [3:0] ACCESS_CNT = 4'(ACCESS_CYC);

  // Status bit positions
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_TIMEOUT = 2;
  localparam int ST_BYPASS  = 3;
  localparam int ST_AUTOSEL = 4;
  localparam int ST_RDY     = 5;

  // Status data bit positions on the flash data bus
  localparam int POLL_BIT    = 7;
  localparam int TOGGLE_BIT  = 6;
  localparam int TIMEOUT_BIT = 5;

endpackage : fch_pkg

// [src/fch_cyc_if.sv]
// Interface between the sequencer and the pin cycle engine
`timescale 1ns/100ps
interface fch_cyc_if;
  logic        req;
  logic        wr;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic        ack;
  logic [15:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input ack, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface : fch_cyc_if

// [src/fch_pin_engine.sv]
// Pin cycle engine: one flash read or write cycle per request
`timescale 1ns/100ps
module fch_pin_engine
  import fch_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  fch_cyc_if.eng           cyc,
  output logic [19:0]      addr_o,
  output logic [15:0]      dq_o,
  output logic             dq_oe_o,
  input  wire logic [15:0] dq_i,
  output logic             ce_n_o,
  output logic             we_n_o,
  output logic             oe_n_o
);

  typedef enum logic [2:0] {E_IDLE, E_SETUP, E_PULSE, E_HOLD, E_ACK} fch_eng_st_t;
  typedef struct packed {
    fch_eng_st_t st;
    logic [3:0]  cnt;
    logic        wr;
    logic [19:0] addr;
    logic [15:0] wd;
    logic [15:0] rd;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic        oe;
    logic        ack;
  } fch_eng_t;

  fch_eng_t s, next_s;

  // Cycle sequencing; chip enable falls first so write enable's fall latches address
  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    case (s.st)
      E_IDLE: begin
        if (cyc.req) begin
          next_s.wr   = cyc.wr;
          next_s.addr = cyc.addr;
          next_s.wd   = cyc.wdata;
          next_s.oe   = cyc.wr;
          next_s.ce_n = 1'b0;
          next_s.cnt  = SETUP_CNT;
          next_s.st   = E_SETUP;
        end
      end
      E_SETUP: begin
        if (s.cnt > 4'h1) begin
          next_s.cnt = s.cnt - 4'h1;
        end else begin
          // Output enable held high for the whole write
          if (s.wr) begin
            next_s.we_n = 1'b0; // Later falling strobe latches address
            next_s.cnt  = PULSE_CNT;
          end else begin
            next_s.oe_n = 1'b0;
            next_s.cnt  = ACCESS_CNT;
          end
          next_s.st = E_PULSE;
        end
      end
      E_PULSE: begin
        if (s.cnt > 4'h1) begin
          next_s.cnt = s.cnt - 4'h1;
        end else begin
          if (!s.wr) begin
            next_s.rd = dq_i;
          end
          next_s.we_n = 1'b1; // Earlier rising strobe latches data
          next_s.oe_n = 1'b1;
          next_s.st   = E_HOLD;
        end
      end
      E_HOLD: begin
        next_s.ce_n = 1'b1;
        next_s.oe   = 1'b0;
        next_s.ack  = 1'b1;
        next_s.st   = E_ACK;
      end
      E_ACK: begin
        next_s.st = E_IDLE;
      end
      default: begin
        next_s.st = E_IDLE;
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s <= '{st: E_IDLE, cnt: 4'h0, wr: 1'b0, addr: 20'h00000, wd: 16'h0000, rd: 16'h0000,
             ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, oe: 1'b0, ack: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign cyc.ack   = s.ack;
  assign cyc.rdata = s.rd;
  assign addr_o    = s.addr;
  assign dq_o      = s.wd;
  assign dq_oe_o   = s.oe;
  assign ce_n_o    = s.ce_n;
  assign we_n_o    = s.we_n;
  assign oe_n_o    = s.oe_n;

endmodule : fch_pin_engine

// [src/fch_apb_regs.sv]
// APB slave holding the controller's command and status registers
`timescale 1ns/100ps
module fch_apb_regs
  import fch_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             go_o,
  output logic [3:0]       op_o,
  output logic [19:0]      addr_o,
  output logic [15:0]      wdata_o,
  input  wire logic [15:0] rdata_i,
  input  wire logic [5:0]  status_i
);

  typedef struct packed {
    logic [3:0]  op;
    logic [19:0] addr;
    logic [15:0] wd;
    logic        go;
    logic [31:0] prd;
    logic        rdy;
    logic        err;
  } fch_reg_t;

  fch_reg_t r, next_r;
  logic     acc;

  // Single wait state: answer one cycle after the access phase begins
  always_comb begin
    next_r = r;
    next_r.go  = 1'b0;
    next_r.rdy = 1'b0;
    next_r.err = 1'b0;
    acc = psel_i && penable_i && !r.rdy;
    if (acc) begin
      next_r.rdy = 1'b1;
      next_r.prd = 32'h00000000;
      case (paddr_i)
        REG_CTRL: begin
          if (pwrite_i) begin
            next_r.op = pwdata_i[3:0];
            next_r.go = !status_i[ST_BUSY];
          end
          next_r.prd = {28'h0000000, r.op};
        end
        REG_ADDR: begin
          if (pwrite_i) next_r.addr = pwdata_i[19:0];
          next_r.prd = {12'h000, r.addr};
        end
        REG_WDATA: begin
          if (pwrite_i) next_r.wd = pwdata_i[15:0];
          next_r.prd = {16'h0000, r.wd};
        end
        REG_RDATA:  next_r.prd = {16'h0000, rdata_i};
        REG_STATUS: next_r.prd = {26'h0000000, status_i};
        default:    next_r.err = 1'b1;
      endcase
    end
  end

  // Register update
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      r <= '{op: 4'h0, addr: 20'h00000, wd: 16'h0000, go: 1'b0, prd: 32'h00000000, rdy: 1'b0, err: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign prdata_o  = r.prd;
  assign pready_o  = r.rdy;
  assign pslverr_o = r.err;
  assign go_o      = r.go;
  assign op_o      = r.op;
  assign addr_o    = r.addr;
  assign wdata_o   = r.wd;

endmodule : fch_apb_regs

// [src/fch_host.sv]
// Top of the flash command host: APB registers, command sequencer and pin engine
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
module fch_host
  import fch_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic [19:0]      flash_addr_o,
  output logic [15:0]      flash_dq_o,
  output logic             flash_dq_oe_o,
  input  wire logic [15:0] flash_dq_i,
  output logic             flash_ce_n_o,
  output logic             flash_we_n_o,
  output logic             flash_oe_n_o,
  output logic             flash_byte_n_o,
  output logic             flash_reset_n_o,
  input  wire logic        ready_busy_n_i
);

  typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_WAIT, S_POLL, S_POLLW, S_FIN} fch_seq_st_t;

  typedef struct packed {
    fch_seq_st_t st;
    logic [3:0]  op;
    logic [2:0]  idx;
    logic [2:0]  len;
    logic        busy;
    logic        done;
    logic        tmo;
    logic        bypass;
    logic        autosel;
    logic [15:0] rdata;
    logic [19:0] paddr;
    logic [15:0] pdata;
  } fch_seq_t;

  fch_seq_t q, next_q;

  logic        go;
  logic [3:0]  op;
  logic [19:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [5:0]  status;
  logic [19:0] cyc_a;
  logic [15:0] cyc_d;
  logic        cyc_w;

  fch_cyc_if cyc ();

  // Length of the bus-cycle sequence for each command
  function automatic logic [2:0] seq_len(input logic [3:0] o);
    case (o)
      OP_RESET, OP_READ, OP_RAW_WR: seq_len = 3'd1;
      OP_BYP_PROG, OP_BYP_EXIT:     seq_len = 3'd2;
      OP_AUTOSEL, OP_BYP_ENTR:      seq_len = 3'd3;
      OP_PROGRAM:                   seq_len = 3'd4;
      default:                      seq_len = 3'd0;
    endcase
  endfunction : seq_len

  // Selects address/data of cycle k for a command; unlock cycles fixed
  always_comb begin
    cyc_a = q.paddr;
    cyc_d = q.pdata;
    cyc_w = 1'b1;
    case (q.op)
      OP_READ: cyc_w = 1'b0;
      OP_RESET: cyc_d = {8'h00, CMD_RESET}; // Single write, address ignored
      OP_AUTOSEL, OP_PROGRAM, OP_BYP_ENTR: begin
        if (q.idx == 3'd0) begin
          cyc_a = UNLOCK1_ADDR;
          cyc_d = {8'h00, UNLOCK1_DATA};
        end else if (q.idx == 3'd1) begin
          cyc_a = UNLOCK2_ADDR;
          cyc_d = {8'h00, UNLOCK2_DATA};
        end else if (q.idx == 3'd2) begin
          cyc_a = UNLOCK1_ADDR;
          cyc_d = (q.op == OP_AUTOSEL) ? {8'h00, CMD_AUTOSEL} :
                  (q.op == OP_BYP_ENTR) ? {8'h00, CMD_BYPASS} :
                  {8'h00, CMD_PROG};
        end
      end
      OP_BYP_PROG: begin
        if (q.idx == 3'd0) cyc_d = {8'h00, CMD_PROG};
      end
      OP_BYP_EXIT: begin
        cyc_d = (q.idx == 3'd0) ? {8'h00, CMD_BYP_EX1} : {8'h00, CMD_BYP_EX2};
      end
      default: begin
        cyc_w = 1'b1;
      end
    endcase
  end

  // Command sequencer
  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    case (q.st)
      S_IDLE: begin
        if (go) begin
          next_q.op    = op;
          next_q.len   = seq_len(op);
          next_q.idx   = 3'd0;
          next_q.paddr = reg_addr;
          next_q.pdata = reg_wdata;
          next_q.tmo   = 1'b0;
          // In bypass only bypass program and exit are legal
          if (seq_len(op) == 3'd0 || (q.bypass && op != OP_BYP_PROG && op != OP_BYP_EXIT)) begin
            next_q.done = 1'b1;
          end else begin
            next_q.busy = 1'b1;
            next_q.st   = S_ISSUE;
          end
        end
      end
      S_ISSUE: begin
        next_q.st = S_WAIT;
      end
      S_WAIT: begin
        if (cyc.ack) begin
          if (q.op == OP_READ) next_q.rdata = cyc.rdata;
          if (q.idx + 3'd1 == q.len) begin
            // Program waits for the embedded algorithm
            next_q.st = (q.op == OP_PROGRAM || q.op == OP_BYP_PROG) ? S_POLL : S_FIN;
          end else begin
            next_q.idx = q.idx + 3'd1;
            next_q.st  = S_ISSUE;
          end
        end
      end
      S_POLL: begin
        next_q.st = S_POLLW;
      end
      S_POLLW: begin
        // Read status at the program address until the polling bit matches data
        if (cyc.ack) begin
          next_q.rdata = cyc.rdata;
          if (cyc.rdata[POLL_BIT] == q.pdata[POLL_BIT] && ready_busy_n_i) begin
            next_q.st = S_FIN;
          end else if (cyc.rdata[TIMEOUT_BIT]) begin
            next_q.tmo = 1'b1; // Software must follow with a reset command
            next_q.st  = S_FIN;
          end else begin
            next_q.st = S_POLL;
          end
        end
      end
      S_FIN: begin
        case (q.op)
          OP_AUTOSEL:  next_q.autosel = 1'b1; // Stays until reset is written
          OP_RESET:    next_q.autosel = 1'b0;
          OP_BYP_ENTR: next_q.bypass  = 1'b1;
          OP_BYP_EXIT: next_q.bypass  = 1'b0;
          default:     next_q.autosel = q.autosel;
        endcase
        next_q.busy = 1'b0;
        next_q.done = 1'b1;
        next_q.st   = S_IDLE;
      end
      default: begin
        next_q.st = S_IDLE;
      end
    endcase
  end

  // Sequencer register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= '{st: S_IDLE, op: 4'h0, idx: 3'd0, len: 3'd0, busy: 1'b0, done: 1'b0,
             tmo: 1'b0, bypass: 1'b0, autosel: 1'b0, rdata: 16'h0000, paddr: 20'h00000,
             pdata: 16'h0000};
    end else begin
      q <= next_q;
    end
  end

  // Registered device-side reset and word mode straps; hardware reset follows ours
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flash_reset_n_o <= 1'b0;
      flash_byte_n_o  <= 1'b1;
    end else begin
      flash_reset_n_o <= 1'b1;
      flash_byte_n_o  <= 1'b1;
    end
  end

  assign cyc.req   = (q.st == S_ISSUE) || (q.st == S_POLL);
  assign cyc.wr    = (q.st == S_ISSUE) ? cyc_w : 1'b0;
  assign cyc.addr  = (q.st == S_POLL) ? q.paddr : cyc_a;
  assign cyc.wdata = cyc_d;
  assign status    = {ready_busy_n_i, q.autosel, q.bypass, q.tmo, q.done, q.busy};

  // Software registers
  fch_apb_regs u_regs (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .prdata_o  (prdata_o),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .go_o      (go),
    .op_o      (op),
    .addr_o    (reg_addr),
    .wdata_o   (reg_wdata),
    .rdata_i   (q.rdata),
    .status_i  (status)
  );

  // Flash pin timing
  fch_pin_engine u_eng (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .cyc     (cyc.eng),
    .addr_o  (flash_addr_o),
    .dq_o    (flash_dq_o),
    .dq_oe_o (flash_dq_oe_o),
    .dq_i    (flash_dq_i),
    .ce_n_o  (flash_ce_n_o),
    .we_n_o  (flash_we_n_o),
    .oe_n_o  (flash_oe_n_o)
  );

endmodule : fch_host

// [verif/fch_host_properties.sv]
// Concurrent checks on the flash pins of the command host
`timescale 1ns/100ps
module fch_host_properties (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [19:0] flash_addr_o,
  input wire logic [15:0] flash_dq_o,
  input wire logic        flash_dq_oe_o,
  input wire logic        flash_ce_n_o,
  input wire logic        flash_we_n_o,
  input wire logic        flash_oe_n_o,
  input wire logic        flash_byte_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Steps of one write strobe: open, then release and deselect
  sequence s_we_open;
    $fell(flash_we_n_o);
  endsequence
  sequence s_we_close;
    flash_we_n_o && !flash_ce_n_o ##1 flash_ce_n_o && !flash_dq_oe_o;
  endsequence

  a_write_gate: assert property (!flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o)
    else $error("write strobe without chip select or with output enable");
  a_we_setup: assert property (s_we_open |-> !$past(flash_ce_n_o) && flash_dq_oe_o)
    else $error("write strobe fell without prior chip select");
  a_read_quiet: assert property (!flash_oe_n_o |-> flash_we_n_o && !flash_dq_oe_o)
    else $error("data bus driven during a read");
  a_we_pulse: assert property (s_we_open |=> s_we_close)
    else $error("write cycle did not close as expected");
  a_cycle_stable: assert property (!flash_ce_n_o && !$past(flash_ce_n_o) && flash_dq_oe_o |->
    $stable(flash_addr_o) && $stable(flash_dq_o))
    else $error("address or data moved inside a write cycle");
  a_read_len: assert property ($fell(flash_oe_n_o) |-> !flash_oe_n_o[*2] ##1 flash_oe_n_o)
    else $error("output enable low for wrong length");
  a_word_mode: assert property (flash_byte_n_o)
    else $error("byte mode selected");
endmodule : fch_host_properties

bind fch_host fch_host_properties fch_host_properties_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o),
  .flash_ce_n_o(flash_ce_n_o), .flash_we_n_o(flash_we_n_o), .flash_oe_n_o(flash_oe_n_o),
  .flash_byte_n_o(flash_byte_n_o));

// [verif/fch_flash_model.sv]
// Behavioural word-mode model of the flash command state machine
`timescale 1ns/100ps
module fch_flash_model
  import fch_pkg::*;
#(
  parameter logic [15:0] MAKER_ID = 16'h00C1, // Arbitrary value
  parameter logic [15:0] DEV_ID   = 16'h0B0B, // Arbitrary value
  parameter logic [3:0]  PROT_SEC = 4'h3,
  parameter int          BUSY_CYC = 30
) (
  input  wire logic        clk_i,
  input  wire logic [19:0] addr_i,
  input  wire logic [15:0] dq_i,
  output logic [15:0]      dq_o,
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        reset_n_i,
  output logic             ready_busy_n_o
);
  typedef enum logic [3:0] {S_RD, S_U1, S_U2, S_PS, S_AS, S_BY, S_BP, S_BX, S_BUSY, S_TO} fch_fst_t;
  fch_fst_t    st = S_RD; // Power-up in read-array
  logic [15:0] mem [256];
  logic [19:0] la;
  logic [19:0] pa;
  logic [15:0] pd;
  logic [15:0] rd;
  logic        tog = 1'b0;
  logic        byp = 1'b0;
  int          cnt;
  wire         wr_act = !ce_n_i && !we_n_i && oe_n_i && reset_n_i;

  initial foreach (mem[i]) mem[i] = 16'hFFFF;
  // Address latched on the later falling strobe
  always @(posedge wr_act) la = addr_i;
  // Data on the earlier rising strobe; one bus write decoded
  always @(negedge wr_act) begin
    case (st)
      S_RD: st = (la == UNLOCK1_ADDR && dq_i[7:0] == UNLOCK1_DATA) ? S_U1 : S_RD;
      S_U1: st = (la == UNLOCK2_ADDR && dq_i[7:0] == UNLOCK2_DATA) ? S_U2 : S_RD;
      S_U2: st = (la != UNLOCK1_ADDR) ? S_RD : (dq_i[7:0] == CMD_PROG) ? S_PS :
                 (dq_i[7:0] == CMD_AUTOSEL) ? S_AS : (dq_i[7:0] == CMD_BYPASS) ? S_BY : S_RD;
      S_PS, S_BP: begin
        if (st == S_PS && dq_i[7:0] == CMD_RESET) begin
          st = S_RD;
        end else begin
          byp = (st == S_BP);
          pa = la;
          pd = dq_i;
          cnt = 0;
          st = ((~mem[la[7:0]] & dq_i) != 16'h0000) ? S_TO : S_BUSY; // Setting a zero bit halts
        end
      end
      S_AS: if (dq_i[7:0] == CMD_RESET) st = S_RD;
      S_BY: st = (dq_i[7:0] == CMD_PROG) ? S_BP : (dq_i[7:0] == CMD_BYP_EX1) ? S_BX : S_BY;
      S_BX: st = (dq_i[7:0] == CMD_BYP_EX2) ? S_RD : S_BY;
      S_TO: if (dq_i[7:0] == CMD_RESET) st = S_RD;
      default: ; // Commands ignored while programming
    endcase
  end
  // Program timer; the hardware reset pin aborts it at the next rising clock
  // Non-blocking so the host never samples the bus or ready pin mid-change
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      st <= S_RD;
    end else if (st == S_BUSY && ++cnt == BUSY_CYC) begin
      mem[pa[7:0]] <= mem[pa[7:0]] & pd; // Only clears bits
      st <= byp ? S_BY : S_RD;
    end
  end
  // Toggle bit flips on every read strobe
  always @(negedge oe_n_i) tog = ~tog;
  // Read mux: status, autoselect codes or array; a released bus shows the inverse
  // No erase suspend in this model, so every sector reads status while programming
  assign rd = (st == S_BUSY || st == S_TO) ? {8'h00, ~pd[7], tog, st == S_TO, 5'h00} :
              (st != S_AS) ? mem[addr_i[7:0]] : (addr_i[7:0] == AS_MAKER) ? MAKER_ID :
              (addr_i[7:0] == AS_DEVICE) ? DEV_ID :
              (addr_i[7:0] == AS_PROT_W) ? {15'h0000, addr_i[19:16] == PROT_SEC} : 16'h0000;
  assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ~rd;
  assign ready_busy_n_o = !(st == S_BUSY || st == S_TO);
endmodule : fch_flash_model

// [verif/tb_top.sv]
// Self-checking testbench for the flash command host
`timescale 1ns/100ps
module tb_top;
  import fch_pkg::*;
  localparam logic [15:0] MAKER = 16'h00C1; // Arbitrary value
  localparam logic [15:0] DEVID = 16'h0B0B; // Arbitrary value
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic [31:0] rv;
  logic        pready_o;
  logic        pslverr_o;
  logic        err;
  logic [19:0] flash_addr_o;
  logic [15:0] flash_dq_o;
  logic [15:0] flash_dq_i;
  logic        flash_dq_oe_o;
  logic        flash_ce_n_o;
  logic        flash_we_n_o;
  logic        flash_oe_n_o;
  logic        flash_byte_n_o;
  logic        flash_reset_n_o;
  logic        ready_busy_n_i;
  int          failures = 0;
  int          n_compared = 0;
  int          cycles = 0;

  always #50 clk_i = ~clk_i;
  fch_host fch_host_i (.*);
  fch_flash_model #(.MAKER_ID(MAKER), .DEV_ID(DEVID)) fch_flash_model_i (.clk_i(clk_i), .addr_i(flash_addr_o),
    .dq_i(flash_dq_o), .dq_o(flash_dq_i), .ce_n_i(flash_ce_n_o), .we_n_i(flash_we_n_o), .oe_n_i(flash_oe_n_o),
    .reset_n_i(flash_reset_n_o), .ready_busy_n_o(ready_busy_n_i));

  task automatic results();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  // Hang guard, well above the 1200 or so cycles the tests need
  always @(posedge clk_i) begin
    if (++cycles == 20000) begin
      failures++;
      results();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One APB transfer; waits for pready with no assumed latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rv = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  // Issue one command and poll until the controller is idle again
  task automatic op(input logic [3:0] code, input logic [19:0] a, input logic [15:0] d);
    apb(1'b1, REG_ADDR, {12'h000, a});
    apb(1'b1, REG_WDATA, {16'h0000, d});
    apb(1'b1, REG_CTRL, {28'h0000000, code});
    do apb(1'b0, REG_STATUS, 32'h0); while (rv[ST_BUSY] !== 1'b0);
  endtask : op
  task automatic rd(input logic [19:0] a, input logic [15:0] exp);
    op(OP_READ, a, 16'h0000);
    apb(1'b0, REG_RDATA, 32'h0);
    check(rv, {16'h0000, exp});
  endtask : rd
  // The done pulse is masked out: it lasts one cycle only
  task automatic stat(input logic [31:0] exp);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rv & 32'h0000003D, exp);
  endtask : stat

  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    stat(32'h20);
    rd(20'h00010, 16'hFFFF);
    $display("test power_up done");
    op(OP_PROGRAM, 20'h00010, 16'h1234);
    rd(20'h00010, 16'h1234);
    op(OP_PROGRAM, 20'h00010, 16'hFFFF);
    stat(32'h04);
    op(OP_RESET, 20'h00000, 16'h0000);
    stat(32'h20);
    rd(20'h00010, 16'h1234);
    $display("test program done");
    op(OP_AUTOSEL, 20'h00000, 16'h0000);
    stat(32'h30);
    rd(20'h54300, MAKER);
    rd(20'h54301, DEVID);
    rd(20'h30002, 16'h0001);
    rd(20'h40002, 16'h0000);
    rd(20'h00000, MAKER);
    op(OP_RESET, 20'h00000, 16'h0000);
    rd(20'h00010, 16'h1234);
    $display("test autoselect done");
    op(OP_BYP_ENTR, 20'h00000, 16'h0000);
    stat(32'h28);
    op(OP_BYP_PROG, 20'h00011, 16'h5A5A);
    op(OP_BYP_PROG, 20'h00012, 16'h00FF);
    op(OP_PROGRAM, 20'h00016, 16'h0000);
    op(OP_BYP_EXIT, 20'h00000, 16'h0000);
    stat(32'h20);
    rd(20'h00011, 16'h5A5A);
    rd(20'h00012, 16'h00FF);
    rd(20'h00016, 16'hFFFF);
    $display("test bypass done");
    op(OP_RAW_WR, UNLOCK1_ADDR, {8'h00, UNLOCK1_DATA});
    op(OP_RAW_WR, 20'h00123, 16'h0055);
    op(OP_PROGRAM, 20'h00013, 16'h0F0F);
    rd(20'h00013, 16'h0F0F);
    op(OP_RAW_WR, UNLOCK1_ADDR, {8'h00, UNLOCK1_DATA});
    op(OP_RESET, 20'h00000, 16'h0000);
    op(OP_PROGRAM, 20'h00014, 16'h0F0F);
    rd(20'h00014, 16'h0F0F);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("test abort done");
    apb(1'b1, REG_ADDR, 32'h15);
    apb(1'b1, REG_WDATA, 32'h0);
    apb(1'b1, REG_CTRL, {28'h0000000, OP_PROGRAM});
    while (ready_busy_n_i !== 1'b0) @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    op(OP_PROGRAM, 20'h00015, 16'h3C3C);
    rd(20'h00015, 16'h3C3C);
    $display("test hardware_reset done");
    results();
  end
endmodule : tb_top
